// ==== rtl/isr_pixclk.v ====
// Pixel clock divider producing the data update enable and the pixel clock output.
`timescale 1ns/1ps
module isr_pixclk (
  input  wire       clock_i,
  input  wire       reset_i,
  input  wire       run_i,
  input  wire [1:0] div_code_i,
  output wire       tick_o,
  output wire       pixel_clock_o
);

  reg  [2:0] cnt_q;
  reg  [2:0] cnt_d;
  wire [2:0] last;
  wire [2:0] half;

  assign last = (3'h1 << div_code_i) - 3'h1;
  assign half = 3'h1 << (div_code_i - 2'h1);

  always @* begin
    if (!run_i || cnt_q >= last) begin
      cnt_d = 3'h0;
    end else begin
      cnt_d = cnt_q + 3'h1;
    end
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Data changes on the tick, where the pixel clock falls; the receiver samples on its rise.
  assign tick_o = run_i && (cnt_q == 3'h0);
  assign pixel_clock_o = !run_i ? 1'b0 :
                         (div_code_i == 2'h0) ? ~clock_i : (cnt_q >= half);

endmodule

// ==== rtl/isr_readout.v ====
// Readout control registers, raster sequencer and pixel output port of the image sensor.
`timescale 1ns/1ps
`include "isr_regs.vh"
module isr_readout (
  input  wire       clock_i,
  input  wire       reset_i,
  input  wire       register_reset_n_i,
  input  wire       power_save_n_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_wr_i,
  output reg  [7:0] reg_rdata_o,
  input  wire [9:0] array_data_i,
  output wire [9:0] array_row_o,
  output wire [9:0] array_col_o,
  output reg  [9:0] pixel_bus_o,
  output wire       pixel_clock_out_o,
  output reg        line_sync_o,
  output reg        frame_sync_o,
  output wire       power_save_o,
  output wire       bad_pixel_replace_o,
  output wire       dark_level_auto_o,
  output wire       channel_separate_o,
  output wire       shutter_enable_o,
  output wire [1:0] adc_resolution_o
);

  // ************************************************************
  // Pin synchronisers and pulse-width qualification
  // ************************************************************
  wire [1:0] pin_raw;
  reg  [1:0] pin_s1_q;
  reg  [1:0] pin_s2_q;
  reg  [2:0] rst_low_q;
  reg  [2:0] stb_low_q;
  wire       pin_reset;
  wire       standby;
  wire       regs_reset;

  assign pin_raw = {power_save_n_i, register_reset_n_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      always @(posedge clock_i) begin
        if (reset_i) begin
          pin_s1_q[gi] <= 1'b1;
          pin_s2_q[gi] <= 1'b1;
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
        end
      end
    end
  endgenerate

  always @(posedge clock_i) begin
    if (reset_i || pin_s2_q[0]) begin
      rst_low_q <= 3'h0;
    end else if (rst_low_q != `ISR_RST_MIN) begin
      rst_low_q <= rst_low_q + 3'h1;
    end
    if (reset_i || pin_s2_q[1]) begin
      stb_low_q <= 3'h0;
    end else if (stb_low_q != `ISR_STBY_MIN) begin
      stb_low_q <= stb_low_q + 3'h1;
    end
  end

  assign pin_reset  = (rst_low_q >= `ISR_RST_MIN - 3'h1) && !pin_s2_q[0];
  assign standby    = (stb_low_q >= `ISR_STBY_MIN - 3'h1) && !pin_s2_q[1];
  assign regs_reset = reset_i || pin_reset;
  assign power_save_o = standby;

  // ************************************************************
  // Control registers
  // ************************************************************
  reg  [5:0] mode_q;
  reg  [7:0] orient_q;
  reg        rs_hi_q;
  reg  [7:0] rs_lo_q;
  reg        cs_hi_q;
  reg  [7:0] cs_lo_q;
  reg        rd_hi_q;
  reg  [7:0] rd_lo_q;
  reg  [1:0] cw_hi_q;
  reg  [7:0] cw_lo_q;
  reg  [7:0] fact_q;
  reg        fdisp_q;
  reg        ldisp_q;

  always @(posedge clock_i) begin
    if (regs_reset) begin
      mode_q   <= `ISR_RST_MODE;
      orient_q <= `ISR_RST_ORIENT;
      rs_hi_q  <= `ISR_RST_RS_HI;
      rs_lo_q  <= `ISR_RST_RS_LO;
      cs_hi_q  <= `ISR_RST_CS_HI;
      cs_lo_q  <= `ISR_RST_CS_LO;
      rd_hi_q  <= `ISR_RST_RD_HI;
      rd_lo_q  <= `ISR_RST_RD_LO;
      cw_hi_q  <= `ISR_RST_CW_HI;
      cw_lo_q  <= `ISR_RST_CW_LO;
      fact_q   <= `ISR_RST_FACT;
      fdisp_q  <= `ISR_RST_DISP;
      ldisp_q  <= `ISR_RST_DISP;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `ISR_A_MODE:   mode_q   <= reg_wdata_i[5:0];
        `ISR_A_ORIENT: orient_q <= reg_wdata_i;
        `ISR_A_RS_HI:  rs_hi_q  <= reg_wdata_i[0];
        `ISR_A_RS_LO:  rs_lo_q  <= reg_wdata_i;
        `ISR_A_CS_HI:  cs_hi_q  <= reg_wdata_i[0];
        `ISR_A_CS_LO:  cs_lo_q  <= reg_wdata_i;
        `ISR_A_RD_HI:  rd_hi_q  <= reg_wdata_i[0];
        `ISR_A_RD_LO:  rd_lo_q  <= reg_wdata_i;
        `ISR_A_CW_HI:  cw_hi_q  <= reg_wdata_i[1:0];
        `ISR_A_CW_LO:  cw_lo_q  <= reg_wdata_i;
        `ISR_A_FACT:   fact_q   <= reg_wdata_i;
        `ISR_A_FSYNC:  fdisp_q  <= reg_wdata_i[`ISR_DISP_BIT];
        `ISR_A_LSYNC:  ldisp_q  <= reg_wdata_i[`ISR_DISP_BIT];
        default: begin
        end
      endcase
    end
  end

  always @* begin
    case (reg_addr_i)
      `ISR_A_MODE:   reg_rdata_o = {2'h0, mode_q};
      `ISR_A_ORIENT: reg_rdata_o = orient_q;
      `ISR_A_RS_HI:  reg_rdata_o = {7'h00, rs_hi_q};
      `ISR_A_RS_LO:  reg_rdata_o = rs_lo_q;
      `ISR_A_CS_HI:  reg_rdata_o = {7'h00, cs_hi_q};
      `ISR_A_CS_LO:  reg_rdata_o = cs_lo_q;
      `ISR_A_RD_HI:  reg_rdata_o = {7'h00, rd_hi_q};
      `ISR_A_RD_LO:  reg_rdata_o = rd_lo_q;
      `ISR_A_CW_HI:  reg_rdata_o = {6'h00, cw_hi_q};
      `ISR_A_CW_LO:  reg_rdata_o = cw_lo_q;
      `ISR_A_FACT:   reg_rdata_o = fact_q;
      `ISR_A_FSYNC:  reg_rdata_o = {3'h0, fdisp_q, 4'h0};
      `ISR_A_LSYNC:  reg_rdata_o = {3'h0, ldisp_q, 4'h0};
      default:       reg_rdata_o = 8'h00;
    endcase
  end

  assign bad_pixel_replace_o = mode_q[`ISR_MODE_BPR];
  assign dark_level_auto_o   = mode_q[`ISR_MODE_DLC];
  assign channel_separate_o  = mode_q[`ISR_MODE_CCS];
  assign shutter_enable_o    = mode_q[`ISR_MODE_SHUT];
  assign adc_resolution_o    = mode_q[1:0];

  // Mask of live pixel bits for a resolution code; code 11b is treated as 10 bits.
  function [9:0] res_mask;
    input [1:0] code;
    begin
      case (code)
        `ISR_RES_8: res_mask = `ISR_MASK_8;
        `ISR_RES_9: res_mask = `ISR_MASK_9;
        default:    res_mask = `ISR_MASK_10;
      endcase
    end
  endfunction

  // Subsampling step for a code: off gives one, then two, three, four.
  function [2:0] sub_step;
    input [1:0] code;
    begin
      sub_step = {1'b0, code} + 3'h1;
    end
  endfunction

  // ************************************************************
  // Pixel clock divider
  // ************************************************************
  wire tick;

  isr_pixclk u_pixclk (
    .clock_i       (clock_i),
    .reset_i       (reset_i),
    .run_i         (!standby),
    .div_code_i    (orient_q[`ISR_OR_DIV_HI:`ISR_OR_DIV_LO]),
    .tick_o        (tick),
    .pixel_clock_o (pixel_clock_out_o)
  );

  // ************************************************************
  // Frame settings, latched at each frame start
  // ************************************************************
  reg  [8:0] f_rs_q;
  reg  [8:0] f_cs_q;
  reg  [8:0] f_rd_q;
  reg  [9:0] f_cw_q;
  reg  [2:0] f_rstep_q;
  reg  [2:0] f_cstep_q;
  reg        f_mirv_q;
  reg        f_mirh_q;

  // ************************************************************
  // Raster sequencer
  // ************************************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_LINE = 2'h1;
  localparam ST_HBLK = 2'h2;
  localparam ST_VBLK = 2'h3;

  reg  [1:0]  state_q;
  reg  [9:0]  col_off_q;
  reg  [9:0]  row_off_q;
  reg  [7:0]  bcnt_q;
  wire [10:0] col_next;
  wire [10:0] row_next;
  wire        frame_load;

  assign col_next = {1'b0, col_off_q} + {8'h00, f_cstep_q};
  assign row_next = {1'b0, row_off_q} + {8'h00, f_rstep_q};
  assign frame_load = tick && (state_q == ST_VBLK) && (bcnt_q == `ISR_VBLANK - 8'h01);

  always @(posedge clock_i) begin
    if (reset_i) begin
      f_rs_q    <= {`ISR_RST_RS_HI, `ISR_RST_RS_LO};
      f_cs_q    <= {`ISR_RST_CS_HI, `ISR_RST_CS_LO};
      f_rd_q    <= {`ISR_RST_RD_HI, `ISR_RST_RD_LO};
      f_cw_q    <= {`ISR_RST_CW_HI, `ISR_RST_CW_LO};
      f_rstep_q <= 3'h1;
      f_cstep_q <= 3'h1;
      f_mirv_q  <= 1'b0;
      f_mirh_q  <= 1'b0;
    end else if (frame_load) begin
      f_rs_q    <= {rs_hi_q, rs_lo_q};
      f_cs_q    <= {cs_hi_q, cs_lo_q};
      f_rd_q    <= {rd_hi_q, rd_lo_q};
      f_cw_q    <= {cw_hi_q, cw_lo_q};
      f_rstep_q <= sub_step(orient_q[`ISR_OR_RSUB_HI:`ISR_OR_RSUB_LO]);
      f_cstep_q <= sub_step(orient_q[`ISR_OR_CSUB_HI:`ISR_OR_CSUB_LO]);
      f_mirv_q  <= orient_q[`ISR_OR_MIRV];
      f_mirh_q  <= orient_q[`ISR_OR_MIRH];
    end
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      state_q   <= ST_VBLK;
      col_off_q <= 10'h000;
      row_off_q <= 10'h000;
      bcnt_q    <= 8'h00;
    end else if (standby) begin
      state_q   <= ST_IDLE;
      col_off_q <= 10'h000;
      row_off_q <= 10'h000;
      bcnt_q    <= 8'h00;
    end else if (tick) begin
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_VBLK;
          bcnt_q  <= 8'h00;
        end
        ST_LINE: begin
          if (col_next >= {1'b0, f_cw_q}) begin
            state_q <= ST_HBLK;
            bcnt_q  <= 8'h00;
          end else begin
            col_off_q <= col_next[9:0];
          end
        end
        ST_HBLK: begin
          if (bcnt_q == `ISR_HBLANK - 8'h01) begin
            bcnt_q    <= 8'h00;
            col_off_q <= 10'h000;
            if (row_next >= {2'h0, f_rd_q}) begin
              state_q <= ST_VBLK;
            end else begin
              state_q   <= ST_LINE;
              row_off_q <= row_next[9:0];
            end
          end else begin
            bcnt_q <= bcnt_q + 8'h01;
          end
        end
        ST_VBLK: begin
          if (bcnt_q == `ISR_VBLANK - 8'h01) begin
            bcnt_q    <= 8'h00;
            col_off_q <= 10'h000;
            row_off_q <= 10'h000;
            state_q   <= ST_LINE;
          end else begin
            bcnt_q <= bcnt_q + 8'h01;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Array address: window start plus offset, counted from the far edge when mirrored.
  assign array_row_o = f_mirv_q ? {1'b0, f_rs_q} + {1'b0, f_rd_q} - 10'h001 - row_off_q
                                : {1'b0, f_rs_q} + row_off_q;
  assign array_col_o = f_mirh_q ? {1'b0, f_cs_q} + f_cw_q - 10'h001 - col_off_q
                                : {1'b0, f_cs_q} + col_off_q;

  // ************************************************************
  // Output port
  // ************************************************************
  wire in_line;
  wire in_rows;
  wire hpulse;
  wire vpulse;

  assign in_line = (state_q == ST_LINE);
  assign in_rows = (state_q == ST_LINE) || (state_q == ST_HBLK);
  assign hpulse  = (state_q == ST_HBLK) && (bcnt_q < `ISR_HSYNC_W);
  assign vpulse  = (state_q == ST_VBLK) && (bcnt_q < `ISR_VSYNC_W);

  always @(posedge clock_i) begin
    if (reset_i || standby) begin
      pixel_bus_o  <= 10'h000;
      line_sync_o  <= 1'b0;
      frame_sync_o <= 1'b0;
    end else if (tick) begin
      pixel_bus_o  <= in_line ? (array_data_i & res_mask(mode_q[1:0])) : 10'h000;
      line_sync_o  <= ldisp_q ? in_line : hpulse;
      frame_sync_o <= fdisp_q ? in_rows : vpulse;
    end
  end

endmodule

// ==== rtl/isr_regs.vh ====
// Register map, field positions, reset values and timing constants of the readout block.
`ifndef ISR_REGS_VH
`define ISR_REGS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define ISR_A_MODE       8'h00
`define ISR_A_ORIENT     8'h01
`define ISR_A_RS_HI      8'h02
`define ISR_A_RS_LO      8'h03
`define ISR_A_CS_HI      8'h04
`define ISR_A_CS_LO      8'h05
`define ISR_A_RD_HI      8'h06
`define ISR_A_RD_LO      8'h07
`define ISR_A_CW_HI      8'h08
`define ISR_A_CW_LO      8'h09
`define ISR_A_FACT       8'h0a
`define ISR_A_FSYNC      8'h12
`define ISR_A_LSYNC      8'h17

// ************************************************************
// Reset values
// ************************************************************
`define ISR_RST_MODE     6'h02
`define ISR_RST_ORIENT   8'h10
`define ISR_RST_RS_HI    1'h0
`define ISR_RST_RS_LO    8'h0e
`define ISR_RST_CS_HI    1'h0
`define ISR_RST_CS_LO    8'h0e
`define ISR_RST_RD_HI    1'h1
`define ISR_RST_RD_LO    8'he0
`define ISR_RST_CW_HI    2'h2
`define ISR_RST_CW_LO    8'h80
`define ISR_RST_FACT     8'h80
`define ISR_RST_DISP     1'h0

// ************************************************************
// Field positions
// ************************************************************
`define ISR_MODE_BPR     5
`define ISR_MODE_DLC     4
`define ISR_MODE_CCS     3
`define ISR_MODE_SHUT    2
`define ISR_MODE_MASK    8'h3f
`define ISR_OR_MIRV      7
`define ISR_OR_MIRH      6
`define ISR_OR_DIV_HI    5
`define ISR_OR_DIV_LO    4
`define ISR_OR_RSUB_HI   3
`define ISR_OR_RSUB_LO   2
`define ISR_OR_CSUB_HI   1
`define ISR_OR_CSUB_LO   0
`define ISR_DISP_BIT     4

// ************************************************************
// Encodings
// ************************************************************
`define ISR_RES_8        2'h0
`define ISR_RES_9        2'h1
`define ISR_MASK_8       10'h3fc
`define ISR_MASK_9       10'h3fe
`define ISR_MASK_10      10'h3ff

// ************************************************************
// Timing constants (master clock periods or pixel clocks)
// ************************************************************
`define ISR_RST_MIN      3'h5
`define ISR_STBY_MIN     3'h4
`define ISR_HBLANK       8'h10
`define ISR_HSYNC_W      8'h04
`define ISR_VBLANK       8'h40
`define ISR_VSYNC_W      8'h10

`endif

// ==== test/isr_host_model.sv ====
// Pixel array and capture side that faces the readout block.
`timescale 1ns/1ps
module isr_host_model (
  input  wire [9:0]  array_row_i,
  input  wire [9:0]  array_col_i,
  input  wire        pixel_clock_i,
  output wire [9:0]  array_data_o,
  output reg  [15:0] rises_o
);
  // Each cell returns a value made of its low row and column bits, so position errors show.
  assign array_data_o = {array_row_i[2:0], array_col_i[6:0]};
  initial rises_o = 16'h0000;
  // The capture side samples on every rising edge of the pixel clock.
  always @(posedge pixel_clock_i) begin
    rises_o <= rises_o + 16'h0001;
  end
endmodule

// ==== test/isr_readout_bench.sv ====
// Self-checking bench for the readout block.
`timescale 1ns/1ps
module isr_readout_bench;
  reg         clock_i = 1'b0;
  reg         reset_i = 1'b1;
  reg         register_reset_n_i = 1'b1;
  reg         power_save_n_i = 1'b1;
  reg  [7:0]  reg_addr_i = 8'h00;
  reg  [7:0]  reg_wdata_i = 8'h00;
  reg         reg_wr_i = 1'b0;
  wire [7:0]  reg_rdata_o;
  wire [9:0]  array_data_i;
  wire [9:0]  array_row_o;
  wire [9:0]  array_col_o;
  wire [9:0]  pixel_bus_o;
  wire        pixel_clock_out_o;
  wire        line_sync_o;
  wire        frame_sync_o;
  wire        power_save_o;
  wire        bad_pixel_replace_o;
  wire        dark_level_auto_o;
  wire        channel_separate_o;
  wire        shutter_enable_o;
  wire [1:0]  adc_resolution_o;
  wire [15:0] rises;
  integer     n_errors = 0;
  integer     compares = 0;
  integer     cycles = 0;
  integer     n_pix;
  integer     n_frame;
  integer     i;
  reg  [15:0] r0;
  reg  [7:0]  d;
  reg  [9:0]  pix [0:63];
  reg  [7:0]  rst_v [0:10] = '{8'h02, 8'h10, 8'h00, 8'h0e, 8'h00, 8'h0e, 8'h01, 8'he0,
                               8'h02, 8'h80, 8'h80};
  reg  [7:0]  msk_v [0:9] = '{8'h3f, 8'hff, 8'h01, 8'hff, 8'h01, 8'hff, 8'h01, 8'hff,
                              8'h03, 8'hff};

  always #5 clock_i = ~clock_i;

  isr_readout uut (.clock_i, .reset_i, .register_reset_n_i, .power_save_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rdata_o, .array_data_i, .array_row_o, .array_col_o,
    .pixel_bus_o, .pixel_clock_out_o, .line_sync_o, .frame_sync_o, .power_save_o,
    .bad_pixel_replace_o, .dark_level_auto_o, .channel_separate_o, .shutter_enable_o,
    .adc_resolution_o);
  isr_host_model partner (.array_row_i(array_row_o), .array_col_i(array_col_o),
    .pixel_clock_i(pixel_clock_out_o), .array_data_o(array_data_i), .rises_o(rises));

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task wrap_up;
    begin
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  always @(posedge clock_i) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: run timed out", $time);
      wrap_up;
    end
  end

  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clock_i) #1;
      reg_addr_i = a;
      reg_wdata_i = v;
      reg_wr_i = 1'b1;
      @(posedge clock_i) #1;
      reg_wr_i = 1'b0;
    end
  endtask

  task rd(input [7:0] a);
    begin
      @(posedge clock_i) #1;
      reg_addr_i = a;
      #2;
      d = reg_rdata_o;
    end
  endtask

  task test_defaults;
    begin
      for (i = 0; i < 11; i = i + 1) begin
        rd(i[7:0]);
        chk(d, rst_v[i]);
      end
      chk({bad_pixel_replace_o, dark_level_auto_o, channel_separate_o, shutter_enable_o,
           adc_resolution_o}, 6'h02);
    end
  endtask

  // Address 0x0a is left untouched, as the host must.
  task test_rw;
    begin
      for (i = 0; i < 10; i = i + 1) begin
        wr(i[7:0], 8'hff);
        rd(i[7:0]);
        chk(d, msk_v[i]);
      end
      chk({bad_pixel_replace_o, dark_level_auto_o, channel_separate_o, shutter_enable_o,
           adc_resolution_o}, 6'h3f);
      wr(8'h0b, 8'hff);
      rd(8'h0b);
      chk(d, 8'h00);
    end
  endtask

  task test_pin_reset;
    begin
      wr(8'h09, 8'h11);
      @(posedge clock_i) #1;
      reg_addr_i = 8'h00;
      register_reset_n_i = 1'b0;
      repeat (10) @(posedge clock_i);
      #1 register_reset_n_i = 1'b1;
      repeat (4) @(posedge clock_i);
      rd(8'h00);
      chk(d, 8'h02);
      rd(8'h09);
      chk(d, 8'h80);
    end
  endtask

  task test_divider;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wr(8'h01, {2'h0, i[1:0], 4'h0});
        repeat (8) @(posedge clock_i);
        #1 r0 = rises;
        repeat (64) @(posedge clock_i);
        #1 chk(rises - r0, 64 >> i);
      end
      wr(8'h01, 8'h10);
    end
  endtask

  task test_standby;
    begin
      wr(8'h09, 8'h55);
      @(posedge clock_i) #1;
      power_save_n_i = 1'b0;
      repeat (8) @(posedge clock_i);
      #1 chk({power_save_o, pixel_bus_o, line_sync_o, frame_sync_o, pixel_clock_out_o},
             {1'b1, 13'h0000});
      power_save_n_i = 1'b1;
      repeat (8) @(posedge clock_i);
      #1 chk(power_save_o, 1'b0);
      rd(8'h09);
      chk(d, 8'h55);
    end
  endtask

  task grab;
    begin
      n_pix = 0;
      n_frame = 0;
      i = 0;
      while (frame_sync_o !== 1'b1 && i < 400) begin
        @(posedge clock_i) #1;
        i = i + 1;
      end
      while (frame_sync_o === 1'b1 && i < 800) begin
        n_frame = n_frame + 1;
        if (line_sync_o === 1'b1) begin
          pix[n_pix[5:0]] = pixel_bus_o;
          n_pix = n_pix + 1;
        end
        @(posedge clock_i) #1;
        i = i + 1;
      end
    end
  endtask

  // Small window of four columns by two rows, valid-level syncs, one clock per pixel.
  task test_frames;
    begin
      @(posedge clock_i) #1;
      reset_i = 1'b1;
      repeat (8) @(posedge clock_i);
      #1 reset_i = 1'b0;
      wr(8'h01, 8'h00);
      wr(8'h00, 8'h00);
      wr(8'h06, 8'h00);
      wr(8'h07, 8'h02);
      wr(8'h08, 8'h00);
      wr(8'h09, 8'h04);
      wr(8'h12, 8'h10);
      wr(8'h17, 8'h10);
      fork
        grab;
        begin
          wait (frame_sync_o === 1'b1);
          wr(8'h01, 8'hc4);
        end
      join
      chk(n_pix, 8);
      chk(n_frame, 40);
      for (i = 0; i < 8; i = i + 1)
        chk(pix[i], ((6 + i / 4) * 128 + 14 + i % 4) & 10'h3fc);
      wr(8'h00, 8'h01);
      grab;
      chk(n_pix, 4);
      chk(n_frame, 20);
      for (i = 0; i < 4; i = i + 1)
        chk(pix[i], (7 * 128 + 17 - i) & 10'h3fe);
    end
  endtask

  task step;
    begin
      @(posedge clock_i) #1;
      i = i + 1;
    end
  endtask

  // Pulse-mode syncs: the frame pulse and the line pulse are counted in pixel ticks.
  task test_pulses;
    begin
      wr(8'h12, 8'h00);
      wr(8'h17, 8'h00);
      i = 0;
      while (frame_sync_o !== 1'b1 && i < 400) step;
      while (frame_sync_o === 1'b1 && i < 400) step;
      while (frame_sync_o !== 1'b1 && i < 400) step;
      n_frame = 0;
      while (frame_sync_o === 1'b1 && i < 400) begin
        n_frame = n_frame + 1;
        step;
      end
      chk(n_frame, 16);
      n_pix = 0;
      while (line_sync_o !== 1'b1 && i < 400) step;
      while (line_sync_o === 1'b1 && i < 400) begin
        n_pix = n_pix + 1;
        step;
      end
      chk(n_pix, 4);
    end
  endtask

  initial begin
    repeat (8) @(posedge clock_i);
    #1 reset_i = 1'b0;
    test_defaults;
    test_rw;
    test_pin_reset;
    test_divider;
    test_standby;
    test_frames;
    test_pulses;
    wrap_up;
  end
endmodule

// ==== test/isr_readout_chk.sv ====
// Port-level assertions for the readout block.
`timescale 1ns/1ps
module isr_readout_chk (
  input wire       clock_i,
  input wire       reset_i,
  input wire       register_reset_n_i,
  input wire       power_save_n_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_wr_i,
  input wire [7:0] reg_rdata_o,
  input wire [9:0] pixel_bus_o,
  input wire       line_sync_o,
  input wire       frame_sync_o,
  input wire       power_save_o,
  input wire       bad_pixel_replace_o,
  input wire       dark_level_auto_o,
  input wire       channel_separate_o,
  input wire       shutter_enable_o,
  input wire [1:0] adc_resolution_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  chk_res_eight_bit: assert property (
    $changed(pixel_bus_o) && $past(adc_resolution_o) == 2'h0 |-> pixel_bus_o[1:0] == 2'h0)
    else $error("low pixel bits set at 8-bit resolution");
  chk_res_nine_bit: assert property (
    $changed(pixel_bus_o) && $past(adc_resolution_o) == 2'h1 |-> pixel_bus_o[0] == 1'b0)
    else $error("low pixel bit set at 9-bit resolution");
  chk_standby_quiet: assert property (
    power_save_o && $past(power_save_o) |-> pixel_bus_o == 10'h000 && !line_sync_o
    && !frame_sync_o) else $error("outputs active in standby");
  chk_standby_enter: assert property (
    !power_save_n_i [*8] |-> power_save_o) else $error("standby not entered");
  chk_standby_leave: assert property (
    power_save_n_i [*8] |-> !power_save_o) else $error("standby not left");
  chk_pin_reset: assert property (
    !register_reset_n_i [*8] ##1 !register_reset_n_i |-> reg_addr_i != 8'h00
    || reg_rdata_o == 8'h02) else $error("mode register not reset by pin");
  chk_mode_fields: assert property (
    reg_addr_i == 8'h00 |-> reg_rdata_o == {2'h0, bad_pixel_replace_o, dark_level_auto_o,
    channel_separate_o, shutter_enable_o, adc_resolution_o}) else $error("mode fields differ");
  chk_unmapped_zero: assert property (
    reg_addr_i > 8'h0a && reg_addr_i != 8'h12 && reg_addr_i != 8'h17 |-> reg_rdata_o == 8'h00)
    else $error("unmapped address reads nonzero");
  chk_high_byte: assert property (
    reg_addr_i == 8'h02 || reg_addr_i == 8'h04 || reg_addr_i == 8'h06
    |-> reg_rdata_o[7:1] == 7'h00) else $error("undefined high bits read nonzero");
  chk_write_back: assert property (
    reg_wr_i && reg_addr_i == 8'h03 && register_reset_n_i && $past(register_reset_n_i, 4)
    ##1 reg_addr_i == 8'h03 |-> reg_rdata_o == $past(reg_wdata_i))
    else $error("written row start not read back");
endmodule
bind isr_readout isr_readout_chk chk_i (.clock_i, .reset_i, .register_reset_n_i,
  .power_save_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rdata_o, .pixel_bus_o,
  .line_sync_o, .frame_sync_o, .power_save_o, .bad_pixel_replace_o, .dark_level_auto_o,
  .channel_separate_o, .shutter_enable_o, .adc_resolution_o);
